/* File: sdpd_pkg.sv */
// Shared constants and types for the synthesizer divider and phase detector core.
package sdpd_pkg;

  localparam int RDIV_W = 14;
  localparam int NDIV_W = 17;
  localparam int FRAC_W = 4;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_RDIV = 4'h4;
  localparam logic [3:0] OFS_NDIV = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hC;

  // Status field positions.
  localparam int STAT_UP_BIT = 0;
  localparam int STAT_DN_BIT = 1;
  localparam int STAT_HIZ_BIT = 2;

  // Divide ranges.
  localparam logic [RDIV_W-1:0] RDIV_MIN = 14'h0001;
  localparam logic [RDIV_W-1:0] RDIV_MAX = 14'h3FFF;
  localparam logic [NDIV_W-1:0] NFRAC_MIN = 17'h00024;
  localparam logic [NDIV_W-1:0] NFRAC_MAX = 17'h0FFFF;
  localparam logic [NDIV_W-1:0] NINT_MIN = 17'h00020;
  localparam logic [NDIV_W-1:0] NINT_MAX = 17'h1001F;

  // Reset values.
  localparam logic [RDIV_W-1:0] RDIV_RST = 14'h0001;
  localparam logic [NDIV_W-1:0] NDIV_RST = 17'h00064;
  localparam logic [3:0] CTRL_RST = 4'hD;

  typedef struct packed {
    logic pump_down_allow;
    logic pump_up_allow;
    logic phase_invert;
    logic integer_mode;
  } sdpd_ctrl_t;

  typedef struct packed {
    logic cp_hiz;
    logic pump_down;
    logic pump_up;
  } sdpd_stat_t;

endpackage

/* File: sdpd_div.sv */
// Programmable edge-count divider producing one pulse every ratio input edges.
`timescale 1ns/100ps
module sdpd_div #(
  parameter int W = 14
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic edge_in,
  input wire logic [W-1:0] ratio,
  output logic div_pulse
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic pulse_r;
  logic pulse_nxt;

  // The new ratio is taken only at reload, so a change never cuts a cycle short.
  always_comb begin
    cnt_nxt = cnt_r;
    pulse_nxt = 1'b0;
    if (edge_in) begin
      if (cnt_r == '0) begin
        pulse_nxt = 1'b1;
        cnt_nxt = ratio - {{(W-1){1'b0}}, 1'b1};
      end else begin
        cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= '0;
      pulse_r <= 1'b0;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign div_pulse = pulse_r;

endmodule

/* File: sdpd_top.sv */
// Reference and RF dividers, phase frequency detector and Avalon-MM control registers.
// How it works
// - Reference divided by 1 to 16383, 14 bits.
// - Fractional RF ratio kept within 36..65535.
// - Integer RF ratio kept within 32..65567.
// - Detector compares only the two divided signals.
// - Invert control swaps up and down outputs.
// - Cleared up allow suppresses pump up.
// - Cleared down allow suppresses pump down.
// - Both cleared: pump high impedance, rest runs.
`timescale 1ns/100ps
module sdpd_top
  import sdpd_pkg::*;
#(
  parameter int RW = RDIV_W,
  parameter int NW = NDIV_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic ref_in,
  input wire logic vco_in,
  input wire logic signed [FRAC_W-1:0] frac_step,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic pump_up,
  output logic pump_down,
  output logic cp_oe_n,
  output logic ref_div_pulse,
  output logic rf_div_pulse
);

  // Register file and bus slave.
  sdpd_ctrl_t ctrl_r, ctrl_nxt;
  logic [RW-1:0] rdiv_r, rdiv_nxt, rdiv_eff_r, rdiv_eff_nxt;
  logic [NW-1:0] ndiv_r, ndiv_nxt, ndiv_eff_r, ndiv_eff_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic signed [NW+1:0] nsum;
  logic signed [NW+1:0] nmin;
  logic signed [NW+1:0] nmax;
  sdpd_stat_t stat;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  assign stat = '{cp_hiz: cp_oe_n, pump_down: pump_down, pump_up: pump_up};

  // A request waits one cycle; the write lands and read data stand at the edge
  // where waitrequest is seen low.
  always_comb begin
    logic [31:0] merged;
    merged = 32'h00000000;
    ctrl_nxt = ctrl_r;
    rdiv_nxt = rdiv_r;
    ndiv_nxt = ndiv_r;
    rdata_nxt = rdata_r;
    wait_nxt = 1'b1;
    if ((avs_read || avs_write) && wait_r) begin
      wait_nxt = 1'b0;
      if (avs_read) begin
        case (avs_address)
          OFS_CTRL: rdata_nxt = {28'h0000000, ctrl_r};
          OFS_RDIV: rdata_nxt = {{(32-RW){1'b0}}, rdiv_r};
          OFS_NDIV: rdata_nxt = {{(32-NW){1'b0}}, ndiv_r};
          OFS_STAT: rdata_nxt = {29'h0000000, stat};
          default: rdata_nxt = 32'h00000000;
        endcase
      end
    end
    if (avs_write && !wait_r) begin
      case (avs_address)
        OFS_CTRL: begin
          merged = be_merge({28'h0000000, ctrl_r}, avs_writedata, avs_byteenable);
          ctrl_nxt = merged[3:0];
        end
        OFS_RDIV: begin
          merged = be_merge({{(32-RW){1'b0}}, rdiv_r}, avs_writedata, avs_byteenable);
          rdiv_nxt = merged[RW-1:0];
        end
        OFS_NDIV: begin
          merged = be_merge({{(32-NW){1'b0}}, ndiv_r}, avs_writedata, avs_byteenable);
          ndiv_nxt = merged[NW-1:0];
        end
        default: merged = 32'h00000000;
      endcase
    end
  end

  assign rdiv_eff_nxt = (rdiv_r < RDIV_MIN) ? RDIV_MIN : rdiv_r;

  // The step from the external modulator only applies in fractional mode.
  always_comb begin
    nsum = $signed({2'b00, ndiv_r});
    if (!ctrl_r.integer_mode) begin
      nsum = nsum + {{(NW+2-FRAC_W){frac_step[FRAC_W-1]}}, frac_step};
    end
    nmin = $signed({2'b00, NFRAC_MIN});
    nmax = $signed({2'b00, NFRAC_MAX});
    if (ctrl_r.integer_mode) begin
      nmin = $signed({2'b00, NINT_MIN});
      nmax = $signed({2'b00, NINT_MAX});
    end
    if (nsum < nmin) begin
      ndiv_eff_nxt = nmin[NW-1:0];
    end else if (nsum > nmax) begin
      ndiv_eff_nxt = nmax[NW-1:0];
    end else begin
      ndiv_eff_nxt = nsum[NW-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      rdiv_r <= RDIV_RST;
      ndiv_r <= NDIV_RST;
      rdiv_eff_r <= RDIV_RST;
      ndiv_eff_r <= NDIV_RST;
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else if (clk_en) begin
      ctrl_r <= ctrl_nxt;
      rdiv_r <= rdiv_nxt;
      ndiv_r <= ndiv_nxt;
      rdiv_eff_r <= rdiv_eff_nxt;
      ndiv_eff_r <= ndiv_eff_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

  // Pin synchronisers. Sampling at the core rate limits the usable input rate to
  // well below a quarter of core_clk; the full-rate paths need dedicated counters.
  logic [2:0] ref_s_r, vco_s_r;
  logic ref_lvl_r, ref_lvl_nxt, vco_lvl_r, vco_lvl_nxt;
  logic ref_edge, vco_edge;

  always_comb begin
    ref_lvl_nxt = (ref_s_r[1] == ref_s_r[2]) ? ref_s_r[2] : ref_lvl_r;
    vco_lvl_nxt = (vco_s_r[1] == vco_s_r[2]) ? vco_s_r[2] : vco_lvl_r;
    ref_edge = ref_lvl_nxt && !ref_lvl_r;
    vco_edge = vco_lvl_nxt && !vco_lvl_r;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_s_r <= 3'h0;
      vco_s_r <= 3'h0;
      ref_lvl_r <= 1'b0;
      vco_lvl_r <= 1'b0;
    end else if (clk_en) begin
      ref_s_r <= {ref_s_r[1:0], ref_in};
      vco_s_r <= {vco_s_r[1:0], vco_in};
      ref_lvl_r <= ref_lvl_nxt;
      vco_lvl_r <= vco_lvl_nxt;
    end
  end

  sdpd_div #(.W(RW)) u_ref_div (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .edge_in(ref_edge),
    .ratio(rdiv_eff_r),
    .div_pulse(ref_div_pulse)
  );

  sdpd_div #(.W(NW)) u_rf_div (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .edge_in(vco_edge),
    .ratio(ndiv_eff_r),
    .div_pulse(rf_div_pulse)
  );

  // Phase frequency detector.
  logic up_raw_r, up_raw_nxt, dn_raw_r, dn_raw_nxt;
  logic pu_nxt, pd_nxt, oe_n_nxt, up_sel, dn_sel;

  always_comb begin
    up_raw_nxt = up_raw_r || ref_div_pulse;
    dn_raw_nxt = dn_raw_r || rf_div_pulse;
    if (up_raw_nxt && dn_raw_nxt) begin
      up_raw_nxt = 1'b0;
      dn_raw_nxt = 1'b0;
    end
    up_sel = ctrl_r.phase_invert ? dn_raw_r : up_raw_r;
    dn_sel = ctrl_r.phase_invert ? up_raw_r : dn_raw_r;
    pu_nxt = up_sel && ctrl_r.pump_up_allow;
    pd_nxt = dn_sel && ctrl_r.pump_down_allow;
    oe_n_nxt = !(ctrl_r.pump_up_allow || ctrl_r.pump_down_allow);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      up_raw_r <= 1'b0;
      dn_raw_r <= 1'b0;
      pump_up <= 1'b0;
      pump_down <= 1'b0;
      cp_oe_n <= 1'b0;
    end else if (clk_en) begin
      up_raw_r <= up_raw_nxt;
      dn_raw_r <= dn_raw_nxt;
      pump_up <= pu_nxt;
      pump_down <= pd_nxt;
      cp_oe_n <= oe_n_nxt;
    end
  end

  a_ref_sets_up: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && ref_div_pulse && !rf_div_pulse && !dn_raw_r |=> up_raw_r && !dn_raw_r)
    else $error("reference edge did not raise up request");
  a_both_clear: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && up_raw_r && rf_div_pulse |=> !up_raw_r && !dn_raw_r)
    else $error("detector did not clear after both edges");
  a_up_masked: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !ctrl_r.pump_up_allow |=> !pump_up)
    else $error("pump up while masked");
  a_down_masked: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !ctrl_r.pump_down_allow |=> !pump_down)
    else $error("pump down while masked");
  a_pump_hiz: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !ctrl_r.pump_up_allow && !ctrl_r.pump_down_allow |=> cp_oe_n && !pump_up)
    else $error("pump not high impedance with both masks");
  a_invert_swap: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && ctrl_r.phase_invert && ctrl_r.pump_up_allow && dn_raw_r |=> pump_up)
    else $error("inverted polarity did not swap outputs");
  a_rdiv_floor: assert property (@(posedge core_clk) disable iff (rst)
    rdiv_eff_r >= RDIV_MIN && rdiv_eff_r <= RDIV_MAX)
    else $error("reference ratio out of range");
  a_nint_range: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && ctrl_r.integer_mode |=> ndiv_eff_r >= NINT_MIN && ndiv_eff_r <= NINT_MAX)
    else $error("integer ratio out of range");
  a_nfrac_range: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !ctrl_r.integer_mode |=> ndiv_eff_r >= NFRAC_MIN && ndiv_eff_r <= NFRAC_MAX)
    else $error("fractional ratio out of range");
  a_bus_wait: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && (avs_read || avs_write) && wait_r |=> !wait_r ##1 wait_r)
    else $error("bus answer not one cycle");

  c_pump_up: cover property (@(posedge core_clk) disable iff (rst) pump_up);
  c_pump_down: cover property (@(posedge core_clk) disable iff (rst) pump_down);
  c_hiz: cover property (@(posedge core_clk) disable iff (rst) cp_oe_n);
  c_read_done: cover property (@(posedge core_clk) disable iff (rst) avs_read && !wait_r);

endmodule

/* File: sdpd_osc_model.sv */
// Behavioural oscillator standing in for the reference source or the VCO.
`timescale 1ns/100ps
module sdpd_osc_model (
  input wire logic core_clk,
  input wire logic run,
  input wire logic [7:0] half,
  output logic osc
);
  logic [7:0] cnt;

  initial begin
    osc = 1'b0;
    cnt = 8'h00;
  end

  // When halted the level is frozen, so the core sees no stray edge.
  always @(posedge core_clk) begin
    if (!run) begin
      cnt <= 8'h00;
    end else if (cnt + 8'h01 >= half) begin
      cnt <= 8'h00;
      osc <= ~osc;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

/* File: sdpd_top_tb.sv */
// Self-checking testbench for the divider and phase detector core.
`timescale 1ns/100ps
module sdpd_top_tb;
  import sdpd_pkg::*;
  logic core_clk, rst, clk_en, avs_read, avs_write, ref_run, vco_run, ref_in, vco_in;
  logic avs_waitrequest, pump_up, pump_down, cp_oe_n, ref_div_pulse, rf_div_pulse;
  logic signed [FRAC_W-1:0] frac_step;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int err_total, checks, gap;
  int rv[3] = '{3, 0, 100};
  int nc[4] = '{13, 13, 12, 12};
  int nv[4] = '{10, 40, 10, 40};
  int nf[4] = '{0, -2, 0, -2};
  int ne[4] = '{32, 40, 36, 38};
  int pc[4] = '{15, 9, 7, 3};
  int pe[4] = '{2, 0, 0, 1};

  always #5 core_clk = ~core_clk;

  sdpd_osc_model i_ref (.core_clk, .run(ref_run), .half(8'h03), .osc(ref_in));
  sdpd_osc_model i_vco (.core_clk, .run(vco_run), .half(8'h03), .osc(vco_in));

  sdpd_top i_dut (.core_clk, .rst, .clk_en, .ref_in, .vco_in, .frac_step, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .pump_up, .pump_down, .cp_oe_n, .ref_div_pulse, .rf_div_pulse);

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One Avalon cycle; the request stands until waitrequest is sampled low.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 100) err_total++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task wait_pulse(input logic rf);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while ((rf ? rf_div_pulse : ref_div_pulse) !== 1'b1 && n < 5000);
    if (n >= 5000) err_total++;
  endtask

  // The first pulse may still use the old ratio, so two are skipped.
  task gap_of(input logic rf);
    wait_pulse(rf);
    wait_pulse(rf);
    gap = 0;
    do begin
      @(posedge core_clk);
      gap++;
    end while ((rf ? rf_div_pulse : ref_div_pulse) !== 1'b1 && gap < 5000);
  endtask

  initial begin
    #300_000;
    err_total++;
    end_sim;
  end

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    frac_step = 4'h0;
    ref_run = 1'b1;
    vco_run = 1'b1;
    err_total = 0;
    checks = 0;
    rd = 32'h0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bus(1'b0, OFS_CTRL, 32'h0, 4'hF);
    check(rd, {28'h0, CTRL_RST});
    bus(1'b0, OFS_NDIV, 32'h0, 4'hF);
    check(rd, 32'h64);
    bus(1'b1, OFS_RDIV, 32'h2000, 4'h2);
    bus(1'b0, OFS_RDIV, 32'h0, 4'hF);
    check(rd, 32'h2001);
    bus(1'b1, 4'h1, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, 4'h1, 32'h0, 4'hF);
    check(rd, 32'h0);
    // A mid-run reset also clears the reference counter, which has already
    // loaded the large ratio above and would otherwise stall the next tests.
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check(32'(avs_waitrequest), 32'h1); // bus idle after reset
    bus(1'b0, OFS_RDIV, 32'h0, 4'hF);
    check(rd, 32'(RDIV_RST));
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, OFS_RDIV, 32'(rv[i]), 4'hF);
      gap_of(1'b0);
      check(32'(gap), 32'(6 * ((rv[i] == 0) ? 1 : rv[i])));
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFS_CTRL, 32'(nc[i]), 4'hF);
      bus(1'b1, OFS_NDIV, 32'(nv[i]), 4'hF);
      frac_step <= 4'(nf[i]);
      gap_of(1'b1);
      check(32'(gap), 32'(6 * ne[i]));
    end
    frac_step <= 4'h0;
    bus(1'b1, OFS_CTRL, 32'hD, 4'hF);
    vco_run <= 1'b0;
    wait_pulse(1'b0);
    wait_pulse(1'b0);
    repeat (3) @(posedge core_clk);
    check(32'({pump_up, pump_down, cp_oe_n}), 32'h4);
    bus(1'b0, OFS_STAT, 32'h0, 4'hF);
    check(rd, 32'h1);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFS_CTRL, 32'(pc[i]), 4'hF);
      repeat (3) @(posedge core_clk);
      check(32'({pump_up, pump_down, cp_oe_n}), 32'(pe[i]));
    end
    gap_of(1'b0);
    check(32'(gap), 32'h258);
    bus(1'b1, OFS_CTRL, 32'hD, 4'hF);
    ref_run <= 1'b0;
    vco_run <= 1'b1;
    wait_pulse(1'b1);
    repeat (3) @(posedge core_clk);
    check(32'({pump_up, pump_down}), 32'h0);
    wait_pulse(1'b1);
    repeat (3) @(posedge core_clk);
    check(32'({pump_up, pump_down}), 32'h1);
    bus(1'b1, OFS_CTRL, 32'hF, 4'hF);
    repeat (3) @(posedge core_clk);
    check(32'({pump_up, pump_down}), 32'h2);
    // Freeze right after a pulse, so the pulse flop is held low.
    wait_pulse(1'b1);
    clk_en <= 1'b0;
    gap = 0;
    repeat (600) begin
      @(posedge core_clk);
      if (rf_div_pulse !== 1'b0) gap++;
    end
    check(32'(gap), 32'h0); // clock enable freeze
    clk_en <= 1'b1;
    gap_of(1'b1);
    check(32'(gap), 32'(6 * ne[1]));
    end_sim;
  end
endmodule
